// file: design/ppsdi_pin_cell.sv
// Purpose: Function select for one port B pin that may carry a port C bit.
// Assumes: Controls come from registers on the same clock.
// Notes: Combinational; the top registers the pad result.
module ppsdi_pin_cell
  import ppsdi_pkg::*;
(
  input wire logic swap,
  input wire logic pin_mode_ctrl,
  input wire logic periph_o,
  input wire logic periph_oe,
  input wire ppsdi_gpio_t gpio_b,
  input wire ppsdi_gpio_t gpio_c,
  output ppsdi_pad_t pad
);
  ppsdi_gpio_t sel;

  always_comb begin
    sel = swap ? gpio_c : gpio_b;
    if (pin_mode_ctrl) begin
      // Peripheral path ignores the swap so the pin keeps its port B function
      pad.o = periph_o;
      pad.oe = periph_oe;
      pad.pu = ~periph_oe & gpio_b.pullup_ctrl;
    end else begin
      pad.o = sel.dat;
      pad.oe = sel.dir;
      pad.pu = ~sel.dir & sel.pullup_ctrl;
    end
  end
endmodule

// file: design/ppsdi_pkg.sv
// Purpose: Constants, maps and carrier types for the port pair switch and direction init block.
// Assumes: Classic Wishbone, 32-bit data, one register per aligned word, byte address = index * 4.
// Notes: Summary of operation follows.
// Summary of operation
// - 64-pin bit 6 swaps B6 for C0
// - 64-pin bit 7 swaps B7 for C1
// - 64-pin bits 5..0 read zero, write zero
// - 48-pin bit 0 swaps B0 for C0
// - 48-pin bit 1 swaps B1 for C1
// - 48-pin bit 3 swaps B3 for C2
// - 48-pin bit 5 swaps B5 for C3
// - 48-pin bits 2,4,6,7 read zero, write zero
// - All selects set gives full port C
// - 64-pin shared pins keep port B peripherals
// - 48-pin shared pins keep port B peripherals
// - Direction bit one means output, zero input
// - Input-only pins have reserved direction bits
// - Pull-up only for inputs with control set
package ppsdi_pkg;
  localparam int ADR_W = 32;
  localparam int DAT_W = 32;
  localparam int PORT_W = 8;
  // Word indices; the byte address is the index times four
  localparam logic [31:0] IDX_SWAP48 = 32'h0008C120;
  localparam logic [31:0] IDX_SWAP64 = 32'h0008C121;
  localparam logic [31:0] IDX_DIR_B = 32'h0008C100;
  localparam logic [31:0] IDX_DIR_C = 32'h0008C101;
  localparam logic [31:0] IDX_OUT_B = 32'h0008C102;
  localparam logic [31:0] IDX_OUT_C = 32'h0008C103;
  localparam logic [31:0] IDX_IN_B = 32'h0008C104;
  localparam logic [31:0] IDX_IN_C = 32'h0008C105;
  localparam logic [31:0] IDX_MODE_B = 32'h0008C106;
  localparam logic [31:0] IDX_PULL_B = 32'h0008C107;
  localparam logic [31:0] IDX_PULL_C = 32'h0008C108;
  localparam logic [31:0] IDX_DIR_P3 = 32'h0008C109;
  localparam logic [31:0] IDX_DIR_PH = 32'h0008C10A;
  localparam logic [31:0] IDX_STATUS = 32'h0008C10B;
  localparam logic [7:0] SWAP64_MASK = 8'hC0;
  localparam logic [7:0] SWAP48_MASK = 8'h2B;
  localparam logic [7:0] SWAP_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] DIR_P3_MASK = 8'hDF;
  localparam logic [7:0] DIR_PH_MASK = 8'h7F;
  localparam logic [31:0] READ_ZERO = 32'h00000000;
  localparam int STAT_PKG64 = 0;
  localparam int STAT_C_FULL = 1;
  // Port C bit carried by each port B pin, entry i for pin B(i)
  localparam logic [7:0][2:0] C_OF_B64 = {3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  localparam logic [7:0][2:0] C_OF_B48 = {3'h0, 3'h0, 3'h3, 3'h0, 3'h2, 3'h0, 3'h1, 3'h0};
  // Port B pin that can carry each port C bit, entry j for bit C(j)
  localparam logic [7:0][2:0] B_OF_C64 = {3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h7, 3'h6};
  localparam logic [7:0][2:0] B_OF_C48 = {3'h0, 3'h0, 3'h0, 3'h0, 3'h5, 3'h3, 3'h1, 3'h0};
  localparam logic [7:0] C_SHARED64 = 8'h03;
  localparam logic [7:0] C_SHARED48 = 8'h0F;

  typedef struct packed {
    logic dat;
    logic dir;
    logic pullup_ctrl;
  } ppsdi_gpio_t;

  typedef struct packed {
    logic o;
    logic oe;
    logic pu;
  } ppsdi_pad_t;
endpackage

// file: design/ppsdi_sync.sv
// Purpose: Two flip-flop synchroniser for pin levels.
// Assumes: Each bit is an independent level.
// Notes: Only the second stage may be read.
module ppsdi_sync #(
  parameter int W = 8
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// file: design/ppsdi_top.sv
// Purpose: Port B / port C pin swapping with its register file on classic Wishbone.
// Assumes: Pins and the package strap are asynchronous and are synchronised here.
// Notes: Peripheral signals for port B come from logic on CLK and are not synchronised.
module ppsdi_top
  import ppsdi_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [DAT_W-1:0] WB_DAT_I,
  output logic [DAT_W-1:0] WB_DAT_O,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_WE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic WB_ACK_O,
  input wire logic PKG_SEL64,
  input wire logic [PORT_W-1:0] PORT_BRAVO_I,
  output logic [PORT_W-1:0] PORT_BRAVO_O,
  output logic [PORT_W-1:0] PORT_BRAVO_OE,
  output logic [PORT_W-1:0] PORT_BRAVO_PU,
  input wire logic [PORT_W-1:0] PORT_CHARLIE_I,
  output logic [PORT_W-1:0] PORT_CHARLIE_O,
  output logic [PORT_W-1:0] PORT_CHARLIE_OE,
  output logic [PORT_W-1:0] PORT_CHARLIE_PU,
  input wire logic [PORT_W-1:0] PERIPH_B_O,
  input wire logic [PORT_W-1:0] PERIPH_B_OE,
  output logic [PORT_W-1:0] PERIPH_B_I,
  output logic [PORT_W-1:0] DIR_PORT3,
  output logic [PORT_W-1:0] DIR_PORTH
);
  logic [7:0] swap_sel_48pin;
  logic [7:0] swap_sel_64pin;
  logic [PORT_W-1:0] pin_direction_b;
  logic [PORT_W-1:0] pin_direction_c;
  logic [PORT_W-1:0] out_data_b;
  logic [PORT_W-1:0] out_data_c;
  logic [PORT_W-1:0] pin_mode_ctrl_b;
  logic [PORT_W-1:0] pullup_ctrl_b;
  logic [PORT_W-1:0] pullup_ctrl_c;
  logic [7:0] pin_direction_p3;
  logic [7:0] pin_direction_ph;
  logic [2*PORT_W:0] sync_d;
  logic [2*PORT_W:0] sync_q;
  logic [PORT_W-1:0] port_bravo_in;
  logic [PORT_W-1:0] port_charlie_in;
  logic pkg64;
  logic [PORT_W-1:0] eff_swap;
  logic [PORT_W-1:0] c_taken;
  logic [PORT_W-1:0] c_in_data;
  logic c_full;
  logic [7:0] status;
  ppsdi_pad_t pad_b [PORT_W];
  ppsdi_pad_t pad_c [PORT_W];
  logic req;
  logic wr_lo;
  logic [29:0] word_idx;
  logic [DAT_W-1:0] next_rdata;

  // Pin levels and the package strap cross in through two flops
  assign sync_d = {PKG_SEL64, PORT_CHARLIE_I, PORT_BRAVO_I};

  ppsdi_sync #(
    .W(2 * PORT_W + 1)
  ) u_sync (
    .CLK(CLK),
    .ARST_N(ARST_N),
    .d(sync_d),
    .q(sync_q)
  );

  assign port_bravo_in = sync_q[PORT_W-1:0];
  assign port_charlie_in = sync_q[2*PORT_W-1:PORT_W];
  assign pkg64 = sync_q[2*PORT_W];

  // Only the register of the strapped package steers the pins; the other is plain storage
  always_comb begin
    if (pkg64) begin
      eff_swap = swap_sel_64pin & SWAP64_MASK;
    end else begin
      eff_swap = swap_sel_48pin & SWAP48_MASK;
    end
  end

  // Port C is a full byte once every select of the live register is set
  always_comb begin
    if (pkg64) begin
      c_full = (swap_sel_64pin & SWAP64_MASK) == SWAP64_MASK;
    end else begin
      c_full = (swap_sel_48pin & SWAP48_MASK) == SWAP48_MASK;
    end
  end

  assign status = {6'h00, c_full, pkg64};

  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_pin
      logic [2:0] c_idx;
      logic [2:0] b_src;
      logic c_shared;
      ppsdi_gpio_t gpio_b;
      ppsdi_gpio_t gpio_c;

      assign c_idx = pkg64 ? C_OF_B64[gi] : C_OF_B48[gi];
      assign gpio_b = '{dat: out_data_b[gi], dir: pin_direction_b[gi], pullup_ctrl: pullup_ctrl_b[gi]};
      assign gpio_c = '{dat: out_data_c[c_idx], dir: pin_direction_c[c_idx], pullup_ctrl: pullup_ctrl_c[c_idx]};

      ppsdi_pin_cell u_cell (
        .swap(eff_swap[gi]),
        .pin_mode_ctrl(pin_mode_ctrl_b[gi]),
        .periph_o(PERIPH_B_O[gi]),
        .periph_oe(PERIPH_B_OE[gi]),
        .gpio_b(gpio_b),
        .gpio_c(gpio_c),
        .pad(pad_b[gi])
      );

      // Port C bit gi may have moved onto a port B pin
      assign b_src = pkg64 ? B_OF_C64[gi] : B_OF_C48[gi];
      assign c_shared = pkg64 ? C_SHARED64[gi] : C_SHARED48[gi];
      assign c_taken[gi] = c_shared & eff_swap[b_src];
      assign c_in_data[gi] = c_taken[gi] ? port_bravo_in[b_src] : port_charlie_in[gi];

      // A native port C pin whose bit moved away is left floating with no pull-up
      always_comb begin
        pad_c[gi].o = out_data_c[gi];
        pad_c[gi].oe = pin_direction_c[gi] & ~c_taken[gi];
        pad_c[gi].pu = ~pin_direction_c[gi] & pullup_ctrl_c[gi] & ~c_taken[gi];
      end
    end
  endgenerate

  // Pad drive is registered; reset clears it so no pull-up is on during reset
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PORT_BRAVO_O <= '0;
      PORT_BRAVO_OE <= '0;
      PORT_BRAVO_PU <= '0;
      PORT_CHARLIE_O <= '0;
      PORT_CHARLIE_OE <= '0;
      PORT_CHARLIE_PU <= '0;
    end else begin
      for (int i = 0; i < PORT_W; i++) begin
        PORT_BRAVO_O[i] <= pad_b[i].o;
        PORT_BRAVO_OE[i] <= pad_b[i].oe;
        PORT_BRAVO_PU[i] <= pad_b[i].pu;
        PORT_CHARLIE_O[i] <= pad_c[i].o;
        PORT_CHARLIE_OE[i] <= pad_c[i].oe;
        PORT_CHARLIE_PU[i] <= pad_c[i].pu;
      end
    end
  end

  // Peripherals always see the port B pins, swapped or not
  assign PERIPH_B_I = port_bravo_in;

  assign DIR_PORT3 = pin_direction_p3;
  assign DIR_PORTH = pin_direction_ph;

  // Bus slave: ack one cycle after the request, dropped for one cycle after each ack
  assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr_lo = req & WB_WE_I & WB_SEL_I[0];
  assign word_idx = WB_ADR_I[31:2];

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= req;
    end
  end

  // Reserved bits are masked on the way in as well as on read
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      swap_sel_48pin <= SWAP_RST;
      swap_sel_64pin <= SWAP_RST;
    end else if (wr_lo) begin
      if (word_idx == IDX_SWAP48[29:0]) begin
        swap_sel_48pin <= WB_DAT_I[7:0] & SWAP48_MASK;
      end
      if (word_idx == IDX_SWAP64[29:0]) begin
        swap_sel_64pin <= WB_DAT_I[7:0] & SWAP64_MASK;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_direction_b <= REG_RST;
      pin_direction_c <= REG_RST;
      pin_direction_p3 <= REG_RST;
      pin_direction_ph <= REG_RST;
    end else if (wr_lo) begin
      if (word_idx == IDX_DIR_B[29:0]) begin
        pin_direction_b <= WB_DAT_I[7:0];
      end
      if (word_idx == IDX_DIR_C[29:0]) begin
        pin_direction_c <= WB_DAT_I[7:0];
      end
      // Input-only pins can never be turned into outputs
      if (word_idx == IDX_DIR_P3[29:0]) begin
        pin_direction_p3 <= WB_DAT_I[7:0] & DIR_P3_MASK;
      end
      if (word_idx == IDX_DIR_PH[29:0]) begin
        pin_direction_ph <= WB_DAT_I[7:0] & DIR_PH_MASK;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      out_data_b <= REG_RST;
      out_data_c <= REG_RST;
    end else if (wr_lo) begin
      if (word_idx == IDX_OUT_B[29:0]) begin
        out_data_b <= WB_DAT_I[7:0];
      end
      if (word_idx == IDX_OUT_C[29:0]) begin
        out_data_c <= WB_DAT_I[7:0];
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_mode_ctrl_b <= REG_RST;
      pullup_ctrl_b <= REG_RST;
      pullup_ctrl_c <= REG_RST;
    end else if (wr_lo) begin
      if (word_idx == IDX_MODE_B[29:0]) begin
        pin_mode_ctrl_b <= WB_DAT_I[7:0];
      end
      if (word_idx == IDX_PULL_B[29:0]) begin
        pullup_ctrl_b <= WB_DAT_I[7:0];
      end
      if (word_idx == IDX_PULL_C[29:0]) begin
        pullup_ctrl_c <= WB_DAT_I[7:0];
      end
    end
  end

  // Read mux; unmapped words answer zero so a stray access never hangs the bus
  always_comb begin
    next_rdata = READ_ZERO;
    if (word_idx == IDX_SWAP48[29:0]) begin
      next_rdata[7:0] = swap_sel_48pin & SWAP48_MASK;
    end else if (word_idx == IDX_SWAP64[29:0]) begin
      next_rdata[7:0] = swap_sel_64pin & SWAP64_MASK;
    end else if (word_idx == IDX_DIR_B[29:0]) begin
      next_rdata[7:0] = pin_direction_b;
    end else if (word_idx == IDX_DIR_C[29:0]) begin
      next_rdata[7:0] = pin_direction_c;
    end else if (word_idx == IDX_OUT_B[29:0]) begin
      next_rdata[7:0] = out_data_b;
    end else if (word_idx == IDX_OUT_C[29:0]) begin
      next_rdata[7:0] = out_data_c;
    end else if (word_idx == IDX_IN_B[29:0]) begin
      next_rdata[7:0] = port_bravo_in;
    end else if (word_idx == IDX_IN_C[29:0]) begin
      next_rdata[7:0] = c_in_data;
    end else if (word_idx == IDX_MODE_B[29:0]) begin
      next_rdata[7:0] = pin_mode_ctrl_b;
    end else if (word_idx == IDX_PULL_B[29:0]) begin
      next_rdata[7:0] = pullup_ctrl_b;
    end else if (word_idx == IDX_PULL_C[29:0]) begin
      next_rdata[7:0] = pullup_ctrl_c;
    end else if (word_idx == IDX_DIR_P3[29:0]) begin
      next_rdata[7:0] = pin_direction_p3 & DIR_P3_MASK;
    end else if (word_idx == IDX_DIR_PH[29:0]) begin
      next_rdata[7:0] = pin_direction_ph & DIR_PH_MASK;
    end else if (word_idx == IDX_STATUS[29:0]) begin
      next_rdata[7:0] = status;
    end
  end

  // Data is loaded only with a read ack, otherwise the last value stays
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      WB_DAT_O <= READ_ZERO;
    end else if (req & ~WB_WE_I) begin
      WB_DAT_O <= next_rdata;
    end
  end
endmodule

// file: verification/ppsdi_asserts.sv
// Purpose: Port-level checks for the port pair switch block.
// Assumes: Single clock domain, asynchronous active-low reset.
// Notes: Sees only top-level ports, so register contents are judged through bus reads.
module ppsdi_asserts
  import ppsdi_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic WB_WE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic [DAT_W-1:0] WB_DAT_O,
  input wire logic [PORT_W-1:0] PORT_BRAVO_OE,
  input wire logic [PORT_W-1:0] PORT_BRAVO_PU,
  input wire logic [PORT_W-1:0] PORT_CHARLIE_OE,
  input wire logic [PORT_W-1:0] PORT_CHARLIE_PU,
  input wire logic [PORT_W-1:0] DIR_PORT3,
  input wire logic [PORT_W-1:0] DIR_PORTH
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req;
  assign req = WB_CYC_I & WB_STB_I;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held past one cycle");
  a_ack_answers: assert property (req && !WB_ACK_O |=> WB_ACK_O) else $error("request not acked in one cycle");
  a_ack_has_cause: assert property (WB_ACK_O |-> $past(req)) else $error("ack without a request");
  a_read_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h000000) else $error("upper data not zero");
  a_swap64_rsv_zero: assert property (WB_ACK_O && $past(!WB_WE_I && WB_ADR_I[31:2] == IDX_SWAP64[29:0])
    |-> WB_DAT_O[5:0] == 6'h00) else $error("64-pin reserved bits read nonzero");
  a_swap48_rsv_zero: assert property (WB_ACK_O && $past(!WB_WE_I && WB_ADR_I[31:2] == IDX_SWAP48[29:0])
    |-> (WB_DAT_O[7:0] & ~SWAP48_MASK) == 8'h00) else $error("48-pin reserved bits read nonzero");
  a_p3_input_only: assert property (DIR_PORT3[5] == 1'b0) else $error("input-only pin a set to output");
  a_ph_input_only: assert property (DIR_PORTH[7] == 1'b0) else $error("input-only pin b set to output");
  a_pullup_b_off: assert property ((PORT_BRAVO_PU & PORT_BRAVO_OE) == 8'h00) else $error("b pull-up on output");
  a_pullup_c_off: assert property ((PORT_CHARLIE_PU & PORT_CHARLIE_OE) == 8'h00) else $error("c pull-up on out");
  c_write_done: cover property (WB_ACK_O && $past(WB_WE_I));
  c_read_swap64: cover property (WB_ACK_O && $past(!WB_WE_I && WB_ADR_I[31:2] == IDX_SWAP64[29:0]));
  c_pin_driven: cover property (PORT_BRAVO_OE != 8'h00);
endmodule

bind ppsdi_top ppsdi_asserts ppsdi_asserts_i (.CLK(CLK), .ARST_N(ARST_N), .WB_ADR_I(WB_ADR_I),
  .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O),
  .PORT_BRAVO_OE(PORT_BRAVO_OE), .PORT_BRAVO_PU(PORT_BRAVO_PU), .PORT_CHARLIE_OE(PORT_CHARLIE_OE),
  .PORT_CHARLIE_PU(PORT_CHARLIE_PU), .DIR_PORT3(DIR_PORT3), .DIR_PORTH(DIR_PORTH));

// file: verification/ppsdi_top_bench.sv
// Purpose: Self-checking bench for the port pair switch block.
// Assumes: Classic Wishbone master in the bench, pins driven as constants.
// Notes: Pad checks wait a few edges so the strap synchroniser and pad flops settle.
module ppsdi_top_bench;
  import ppsdi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A48 = 32'h00230480;
  localparam logic [31:0] A64 = 32'h00230484;
  localparam logic [31:0] ADB = 32'h00230400;
  localparam logic [31:0] ADC = 32'h00230404;
  localparam logic [31:0] AOC = 32'h0023040C;
  localparam logic [31:0] AIC = 32'h00230414;
  localparam logic [31:0] AMB = 32'h00230418;
  localparam logic [31:0] APB = 32'h0023041C;
  localparam logic [31:0] AP3 = 32'h00230424;
  localparam logic [31:0] APH = 32'h00230428;
  localparam logic [31:0] AST = 32'h0023042C;
  localparam logic [31:0] AUN = 32'h00001000;
  logic clk, arst_n, we, cyc, stb, ack, pkg;
  logic [31:0] adr, wdat, rdat, q;
  logic [3:0] sel;
  logic [7:0] bi, bo, boe, bpu, ci, co, coe, cpu, pbo, pboe, pbi, d3, dh;
  int n_fail = 0;
  int total_checks = 0;

  ppsdi_top ppsdi_top_i (.CLK(clk), .ARST_N(arst_n), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack), .PKG_SEL64(pkg),
    .PORT_BRAVO_I(bi), .PORT_BRAVO_O(bo), .PORT_BRAVO_OE(boe), .PORT_BRAVO_PU(bpu),
    .PORT_CHARLIE_I(ci), .PORT_CHARLIE_O(co), .PORT_CHARLIE_OE(coe), .PORT_CHARLIE_PU(cpu),
    .PERIPH_B_O(pbo), .PERIPH_B_OE(pboe), .PERIPH_B_I(pbi), .DIR_PORT3(d3), .DIR_PORTH(dh));

  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until ack is sampled high or 20 edges pass; released at that edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) n_fail++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(q, e);
  endtask

  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task stop_test;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    stop_test;
  end

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    {we, cyc, stb} = 3'h0;
    adr = 32'h00000000;
    wdat = 32'h00000000;
    // Every register is one byte in lane 0, so all writes are byte-wide
    sel = 4'h1;
    pkg = 1'b1;
    bi = 8'hA5;
    ci = 8'h3C;
    pbo = 8'h00;
    pboe = 8'h00;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    rd(A48, 32'h00);
    rd(A64, 32'h00);
    wr(A64, 32'hFF);
    rd(A64, 32'hC0);
    wr(ADC, 32'h03);
    wr(AOC, 32'h02);
    settle;
    chk(bo & 8'hC0, 8'h80);
    chk(boe & 8'hC0, 8'hC0);
    chk(coe & 8'h03, 8'h00);
    pbo <= 8'h40;
    pboe <= 8'hC0;
    wr(AMB, 32'hC0);
    settle;
    chk(bo & 8'hC0, 8'h40);
    wr(AMB, 32'h00);
    wr(ADC, 32'h00);
    wr(A64, 32'h00);
    wr(ADC, 32'h03);
    settle;
    chk(boe & 8'hC0, 8'h00);
    chk(coe & 8'h03, 8'h03);
    // Strap change while all swaps are clear, as software must
    wr(ADC, 32'h00);
    pkg <= 1'b0;
    wr(A48, 32'hFF);
    rd(A48, 32'h2B);
    wr(ADC, 32'h0F);
    wr(AOC, 32'h05);
    settle;
    chk(bo & 8'h2B, 8'h09);
    chk(boe & 8'h2B, 8'h2B);
    chk(co, 8'h05);
    rd(AST, 32'h02);
    rd(AIC, 32'h39);
    pbo <= 8'h22;
    pboe <= 8'h0B;
    wr(AMB, 32'h2B);
    wr(APB, 32'hFF);
    // Port B direction makes B6 and B7 outputs and leaves B2 an input with pull-up
    wr(ADB, 32'hC0);
    settle;
    chk(bo & 8'h2B, 8'h22);
    chk(boe & 8'h2B, 8'h0B);
    chk(bpu & 8'h2B, 8'h20);
    chk(boe & 8'hC4, 8'hC0);
    chk(bpu & 8'hC4, 8'h04);
    chk(pbi, 8'hA5);
    wr(AP3, 32'hFF);
    wr(APH, 32'hFF);
    settle;
    chk(d3, 8'hDF);
    chk(dh, 8'h7F);
    rd(AP3, 32'hDF);
    wr(AUN, 32'hFF);
    rd(AUN, 32'h00);
    stop_test;
  end
endmodule
